// File: cpu_compare_pwm.v
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "cpu_map.vh"
// Notes on behaviour
// - mode field: off, compare actions, PWM
// - compare value against timer one; flag
// - zero control forces compare latch low
// - software-interrupt mode: flag only, pin untouched
// - unit one trigger resets timer one
// - unit two trigger also starts conversion
// - trigger reset never sets overflow flag
// - PWM output with ten-bit duty
// - zero control forces PWM latch low
// - period match clears timer, sets pin unless duty is zero, loads duty
// - postscaler does not affect PWM period
// - duty is low register plus control bits
// - duty loads at period; high read-only
// - duty double-buffered with hidden latch
// - pin clears when duty meets extended count
// - duty beyond period never clears pin
// - prescaler ratios one, four, sixteen
module cpu_compare_pwm #(
    parameter NUNITS = 2
) (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire adc_enabled_in,
    output reg [NUNITS-1:0] unit_output_pin_out,
    output reg [15:0] timer_one_count_out,
    output reg timer_one_overflow_flag_out,
    output reg timer_two_match_out,
    output reg adc_start_out
);
    // ==========================================================
    // registers
    reg [7:0] low_r [0:NUNITS-1];
    reg [7:0] high_r [0:NUNITS-1];
    reg [7:0] ctrl_r [0:NUNITS-1];
    reg [1:0] dlatch_r [0:NUNITS-1];
    reg [NUNITS-1:0] flag_r;
    reg [NUNITS-1:0] pin_r;
    reg [7:0] period_r;
    reg [6:0] t2ctl_r;
    reg [7:0] t2_r;
    reg [1:0] phase_r;
    reg [3:0] pre_r;
    reg [3:0] post_r;
    reg t2_flag_r;
    reg [15:0] t1_r;
    reg t1_ovf_r;
    reg ack_r;
    wire acc = (avs_read_in | avs_write_in) & ~ack_r;
    wire wr = avs_write_in & ~ack_r & avs_byteenable_in[0];
    wire [7:0] wd = avs_writedata_in[7:0];
    // ==========================================================
    // timer two time base
    // prescale ratio 1, 4 or 16 a tick advances the 2-bit phase
    wire [3:0] pre_lim = t2ctl_r[1] ? 4'hF : (t2ctl_r[0] ? 4'h3 : 4'h0);
    wire t2_on = t2ctl_r[`CPU_T2_ON_BIT];
    wire tick = t2_on && (pre_r == pre_lim);
    wire t2_inc = tick && (phase_r == 2'h3);
    wire per_match = t2_inc && (t2_r == period_r);
    // low count bits: quarter phase at 1:1, prescaled steps otherwise,
    // so one duty step is always one prescaled clock
    wire [9:0] ext_cnt = {t2_r, phase_r};
    // look one step ahead: the pin falls on the edge the count reaches duty
    wire [9:0] ext_next = ext_cnt + 10'h001;
    // ==========================================================
    // per-unit mode and events
    wire [NUNITS-1:0] is_pwm;
    wire [NUNITS-1:0] trig;
    generate
        genvar gi;
        for (gi = 0; gi < NUNITS; gi = gi + 1) begin : g_unit
            assign is_pwm[gi] = (ctrl_r[gi][3:2] == 2'h3);
            assign trig[gi] = (ctrl_r[gi][3:0] == `CPU_MODE_TRG) &&
                              ({high_r[gi], low_r[gi]} == t1_r);
        end
    endgenerate
    wire any_trig = |trig;
    // hardware sets win over a software clear in the same cycle
    wire ovf_set = !any_trig && (t1_r == 16'hFFFF);
    wire t2_set = per_match && (post_r == t2ctl_r[6:3]);
    integer i;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (i = 0; i < NUNITS; i = i + 1) begin
                low_r[i] <= 8'h00;
                high_r[i] <= 8'h00;
                ctrl_r[i] <= `CPU_CTRL_RST;
                dlatch_r[i] <= 2'h0;
            end
            flag_r <= {NUNITS{1'b0}};
            pin_r <= {NUNITS{1'b0}};
        end else begin
            for (i = 0; i < NUNITS; i = i + 1) begin
                if (ctrl_r[i][3:0] == `CPU_MODE_OFF) begin
                    pin_r[i] <= 1'b0;
                end else if (ctrl_r[i][3]) begin
                    if (is_pwm[i]) begin
                        if (per_match) begin
                            // load buffered duty, set pin unless zero
                            high_r[i] <= low_r[i];
                            dlatch_r[i] <= ctrl_r[i][`CPU_DLOW_MSB:`CPU_DLOW_LSB];
                            pin_r[i] <= |{low_r[i], ctrl_r[i][5:4]};
                        end else if (tick && {high_r[i], dlatch_r[i]} == ext_next) begin
                            // long duty never reaches count, so pin stays
                            pin_r[i] <= 1'b0;
                        end
                    end else if ({high_r[i], low_r[i]} == t1_r) begin
                        if (ctrl_r[i][3:0] == `CPU_MODE_SET) pin_r[i] <= 1'b1;
                        if (ctrl_r[i][3:0] == `CPU_MODE_CLR) pin_r[i] <= 1'b0;
                        // software-interrupt and trigger modes leave pin
                    end
                end
                // set wins over software clear
                if (ctrl_r[i][3:2] == 2'h2 && {high_r[i], low_r[i]} == t1_r)
                    flag_r[i] <= 1'b1;
                else if (wr && avs_address_in == `CPU_IDX_FLAGS && wd[i])
                    flag_r[i] <= 1'b0;
            end
            if (wr) begin
                case (avs_address_in)
                    `CPU_IDX_U1_LOW: low_r[0] <= wd;
                    `CPU_IDX_U1_HIGH: if (!is_pwm[0]) high_r[0] <= wd;
                    `CPU_IDX_U1_CTRL: ctrl_r[0] <= wd & `CPU_CTRL_MASK;
                    `CPU_IDX_U2_LOW: low_r[NUNITS-1] <= wd;
                    `CPU_IDX_U2_HIGH: if (!is_pwm[NUNITS-1]) high_r[NUNITS-1] <= wd;
                    `CPU_IDX_U2_CTRL: ctrl_r[NUNITS-1] <= wd & `CPU_CTRL_MASK;
                    default: ;
                endcase
            end
        end
    end
    // ==========================================================
    // timers and shared registers
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            period_r <= `CPU_PERIOD_RST;
            t2ctl_r <= 7'h00;
            t2_r <= 8'h00;
            phase_r <= 2'h0;
            pre_r <= 4'h0;
            post_r <= 4'h0;
            t2_flag_r <= 1'b0;
            t1_r <= 16'h0000;
            t1_ovf_r <= 1'b0;
        end else begin
            if (t2_on) begin
                pre_r <= tick ? 4'h0 : pre_r + 4'h1;
                if (tick) phase_r <= phase_r + 2'h1;
            end
            if (per_match) begin
                t2_r <= 8'h00;
                // postscaler only paces the period flag, not the PWM
                if (post_r == t2ctl_r[6:3]) begin
                    post_r <= 4'h0;
                    t2_flag_r <= 1'b1;
                end else begin
                    post_r <= post_r + 4'h1;
                end
            end else if (t2_inc) begin
                t2_r <= t2_r + 8'h01;
            end
            // timer one modelled as free-running synchronous timer
            if (any_trig) begin
                t1_r <= 16'h0000;
            end else begin
                t1_r <= t1_r + 16'h0001;
                if (t1_r == 16'hFFFF) t1_ovf_r <= 1'b1;
            end
            if (wr) begin
                case (avs_address_in)
                    `CPU_IDX_PERIOD: period_r <= wd;
                    `CPU_IDX_T2CTRL: t2ctl_r <= wd[6:0];
                    `CPU_IDX_STATUS: begin
                        if (wd[0] && !ovf_set) t1_ovf_r <= 1'b0;
                        if (wd[1] && !t2_set) t2_flag_r <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end
    // ==========================================================
    // avalon slave: one wait cycle, then answer
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
        end else begin
            ack_r <= acc;
            avs_waitrequest_out <= ~acc;
            avs_readdata_out <= 32'h00000000;
            if (acc && avs_read_in) begin
                case (avs_address_in)
                    `CPU_IDX_U1_LOW: avs_readdata_out[7:0] <= low_r[0];
                    `CPU_IDX_U1_HIGH: avs_readdata_out[7:0] <= high_r[0];
                    `CPU_IDX_U1_CTRL: avs_readdata_out[7:0] <= ctrl_r[0];
                    `CPU_IDX_U2_LOW: avs_readdata_out[7:0] <= low_r[NUNITS-1];
                    `CPU_IDX_U2_HIGH: avs_readdata_out[7:0] <= high_r[NUNITS-1];
                    `CPU_IDX_U2_CTRL: avs_readdata_out[7:0] <= ctrl_r[NUNITS-1];
                    `CPU_IDX_PERIOD: avs_readdata_out[7:0] <= period_r;
                    `CPU_IDX_T2CTRL: avs_readdata_out[7:0] <= {1'b0, t2ctl_r};
                    `CPU_IDX_FLAGS: avs_readdata_out[NUNITS-1:0] <= flag_r;
                    `CPU_IDX_STATUS: avs_readdata_out[9:0] <= {t2_r, t2_flag_r, t1_ovf_r};
                    default: avs_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end
    // ==========================================================
    // registered outputs
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_output_pin_out <= {NUNITS{1'b0}};
            timer_one_count_out <= 16'h0000;
            timer_one_overflow_flag_out <= 1'b0;
            timer_two_match_out <= 1'b0;
            adc_start_out <= 1'b0;
        end else begin
            unit_output_pin_out <= pin_r;
            timer_one_count_out <= t1_r;
            timer_one_overflow_flag_out <= t1_ovf_r;
            timer_two_match_out <= t2_flag_r;
            adc_start_out <= trig[NUNITS-1] & adc_enabled_in;
        end
    end
endmodule

// File: cpu_map.vh
`ifndef CPU_MAP_VH
`define CPU_MAP_VH
// ==========================================================
// register indices (byte address = index * 4)
`define CPU_IDX_U1_LOW 8'h15
`define CPU_IDX_U1_HIGH 8'h16
`define CPU_IDX_U1_CTRL 8'h17
`define CPU_IDX_U2_LOW 8'h1B
`define CPU_IDX_U2_HIGH 8'h1C
`define CPU_IDX_U2_CTRL 8'h1D
`define CPU_IDX_PERIOD 8'h20
`define CPU_IDX_T2CTRL 8'h21
`define CPU_IDX_FLAGS 8'h22
`define CPU_IDX_STATUS 8'h23
// ==========================================================
// field layout
`define CPU_MODE_MSB 3
`define CPU_DLOW_MSB 5
`define CPU_DLOW_LSB 4
`define CPU_CTRL_MASK 8'h3F
`define CPU_T2CTL_MASK 8'h7F
`define CPU_T2_ON_BIT 2
`define CPU_CTRL_RST 8'h00
`define CPU_PERIOD_RST 8'hFF
// ==========================================================
// mode codes
`define CPU_MODE_OFF 4'h0
`define CPU_MODE_SET 4'h8
`define CPU_MODE_CLR 4'h9
`define CPU_MODE_SWI 4'hA
`define CPU_MODE_TRG 4'hB
`endif

// File: cpu_compare_pwm_assertions.sv
`timescale 1ns/10ps
// ====================
// port checker
module cpu_chk #(
    parameter NUNITS = 2
) (
    input wire clk_in,
    input wire rst_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire [NUNITS-1:0] unit_output_pin_out,
    input wire [15:0] timer_one_count_out,
    input wire timer_one_overflow_flag_out,
    input wire adc_start_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire req = avs_read_in | avs_write_in;
    ack_once_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("no answer one cycle after request");
    ack_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer held too long");
    idle_hold_a: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer without request");
    rdata_upper_a: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    trig_pulse_a: assert property (adc_start_out |=> !adc_start_out)
        else $error("conversion start too long");
    trig_reset_a: assert property (adc_start_out |-> ##[0:3] timer_one_count_out == 16'h0)
        else $error("trigger did not reset timer");
    timer_step_a: assert property (
        timer_one_count_out != $past(timer_one_count_out) + 16'h1
        |-> timer_one_count_out == 16'h0) else $error("timer jumped");
    ovf_cause_a: assert property (
        $rose(timer_one_overflow_flag_out) |-> $past(timer_one_count_out) == 16'hFFFF)
        else $error("overflow flag without wrap");
    cover property (adc_start_out);
    cover property ($rose(unit_output_pin_out[0]));
    cover property ($fell(unit_output_pin_out[0]));
endmodule
bind cpu_compare_pwm cpu_chk #(.NUNITS(NUNITS)) cpu_chk_inst (.clk_in(clk_in), .rst_in(rst_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .unit_output_pin_out(unit_output_pin_out),
    .timer_one_count_out(timer_one_count_out), .adc_start_out(adc_start_out),
    .timer_one_overflow_flag_out(timer_one_overflow_flag_out));

// File: cpu_pin_load.sv
`timescale 1ns/10ps
// ====================
// load on the pin: measures high time and period in clocks
module cpu_pin_load (
    input wire clk_in,
    input wire pin_in, // pin direction already set to output
    output logic [15:0] high_len_out = 16'h0,
    output logic [15:0] period_len_out = 16'h0
);
    logic [15:0] hc_r = 16'h0;
    logic [15:0] pc_r = 16'h0;
    logic last_r = 1'b0;
    always @(posedge clk_in) begin
        last_r <= pin_in;
        pc_r <= pc_r + 16'h1;
        if (pin_in && !last_r) begin
            period_len_out <= pc_r;
            pc_r <= 16'h1;
            hc_r <= 16'h1;
        end else if (pin_in) begin
            hc_r <= hc_r + 16'h1;
        end else if (last_r) begin
            high_len_out <= hc_r;
        end
    end
endmodule

// File: cpu_compare_pwm_bench.sv
`timescale 1ns/10ps
module cpu_compare_pwm_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] adr = 8'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic adc_en = 1'b1;
    logic ok;
    wire [31:0] rdat;
    wire wreq;
    wire [1:0] pin;
    wire [15:0] t1;
    wire [15:0] hi_len;
    wire [15:0] per_len;
    wire ovf;
    wire adc_go;
    wire t2m;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int adc_cnt = 0;
    int n;
    always #5 clk_in = ~clk_in;
    cpu_compare_pwm cpu_compare_pwm_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .adc_enabled_in(adc_en),
        .unit_output_pin_out(pin), .timer_one_count_out(t1), .timer_one_overflow_flag_out(ovf),
        .timer_two_match_out(t2m), .adc_start_out(adc_go));
    cpu_pin_load cpu_pin_load_inst (.clk_in(clk_in), .pin_in(pin[0]), .high_len_out(hi_len),
        .period_len_out(per_len));
    // ====================
    // helpers
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (adc_go === 1'b1) adc_cnt <= adc_cnt + 1;
        if (cyc == 90000) begin
            mismatches++;
            close_out;
        end
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // bus cycle: held until waitrequest is sampled low
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_in);
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do @(posedge clk_in); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task wr8(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask
    task rd8(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        acc(1'b0, a, 8'h0, q);
        chk(nm, q, e);
    endtask
    task wait_pin(input logic v);
        for (n = 0; n < 600 && pin[0] !== v; n++) @(posedge clk_in);
        chk("pin", {31'h0, pin[0]}, {31'h0, v});
    endtask
    task hold(input logic v);
        ok = 1'b1;
        repeat (300) begin
            @(posedge clk_in);
            if (pin[0] !== v) ok = 1'b0;
        end
    endtask
    // ====================
    // scenarios
    task t_regs;
        rd8(8'h17, 32'h0, "ctrl1 reset");
        rd8(8'h20, 32'hFF, "period reset");
        rd8(8'h30, 32'h0, "unmapped");
        wr8(8'h1D, 8'hC0);
        rd8(8'h1D, 32'h0, "ctrl2 top bits");
        $display("test regs done");
    endtask
    task t_trig;
        wr8(8'h1C, 8'h01);
        wr8(8'h1B, 8'h00);
        wr8(8'h1D, 8'h0B);
        for (n = 0; n < 600 && adc_go !== 1'b1; n++) @(posedge clk_in);
        chk("adc start", {31'h0, adc_go}, 32'h1);
        repeat (3) @(posedge clk_in);
        chk("t1 reset", {31'h0, t1 < 16'h8}, 32'h1);
        chk("t1 ovf", {31'h0, ovf}, 32'h0);
        chk("pin2", {31'h0, pin[1]}, 32'h0);
        rd8(8'h22, 32'h2, "flag2");
        wr8(8'h22, 8'h02);
        rd8(8'h22, 32'h0, "flag2 clear");
        adc_en <= 1'b0;
        n = adc_cnt;
        repeat (300) @(posedge clk_in);
        chk("adc off", adc_cnt, n);
        adc_en <= 1'b1;
        $display("test trigger done");
    endtask
    task t_cmp;
        wr8(8'h16, 8'h00);
        wr8(8'h15, 8'h80);
        wr8(8'h17, 8'h08); // timer one runs synchronously inside the block
        wait_pin(1'b1);
        wr8(8'h17, 8'h09);
        wait_pin(1'b0);
        wr8(8'h17, 8'h08);
        wait_pin(1'b1);
        wr8(8'h22, 8'h03);
        wr8(8'h17, 8'h0A);
        hold(1'b1);
        chk("swi pin", {31'h0, ok}, 32'h1);
        rd8(8'h22, 32'h3, "flags sticky");
        // unit one trigger keeps timer one below unit two's match
        wr8(8'h17, 8'h0B);
        repeat (260) @(posedge clk_in);
        n = adc_cnt;
        repeat (300) @(posedge clk_in);
        chk("u1 trig adc", adc_cnt, n);
        chk("u1 trig t1", {31'h0, t1 <= 16'h80}, 32'h1);
        wr8(8'h17, 8'h00);
        repeat (2) @(posedge clk_in);
        chk("off pin", {31'h0, pin[0]}, 32'h0);
        $display("test compare done");
    endtask
    task t_pwm;
        logic [7:0] ps;
        int f;
        wr8(8'h1D, 8'h00);
        wr8(8'h20, 8'h03);
        wr8(8'h15, 8'h01);
        wr8(8'h17, 8'h20);
        for (int i = 0; i < 3; i++) begin
            // middle pass also runs the postscaler at its slowest ratio
            ps = (i == 0) ? 8'h04 : ((i == 1) ? 8'h7D : 8'h06);
            f = 1 << (2 * i);
            wr8(8'h21, ps);
            if (i == 0) wr8(8'h17, 8'h2C); // PWM mode selected last
            repeat (48 * f + 8) @(posedge clk_in);
            chk("period", per_len, 16 * f);
            chk("high", hi_len, 6 * f);
        end
        chk("t2 flag", {31'h0, t2m}, 32'h1);
        wr8(8'h16, 8'h55);
        rd8(8'h16, 32'h01, "high ro");
        wr8(8'h15, 8'h05);
        repeat (600) @(posedge clk_in);
        hold(1'b1);
        chk("long duty", {31'h0, ok}, 32'h1);
        wr8(8'h17, 8'h00);
        repeat (2) @(posedge clk_in);
        chk("pwm off", {31'h0, pin[0]}, 32'h0);
        wr8(8'h15, 8'h00);
        wr8(8'h17, 8'h0C);
        hold(1'b0);
        chk("zero duty", {31'h0, ok}, 32'h1);
        $display("test pwm done");
    endtask
    task t_ovf;
        // timer one free-runs from here, a natural wrap must raise the flag
        for (int k = 0; k < 70000 && ovf !== 1'b1; k++) @(posedge clk_in);
        chk("t1 wrap flag", {31'h0, ovf}, 32'h1);
        $display("test overflow done");
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_regs;
        t_trig;
        t_cmp;
        t_pwm;
        t_ovf;
        close_out;
    end
endmodule
